// ==== verilog/scm_regs.sv ====
// Clock gating, prescaler and channel mode registers of a two-channel serial unit.
// Assumes CPU writes arrive as single-cycle strobes on CORE_CLK; clock outputs are enables.
//
// Contract
// - Unit enable low stops clock, holds reset
// - Unit disabled: registers default, writes ignored
// - System reset clears peripheral enable register
// - Prescaler nibbles choose two shared clocks
// - Nibble k divides clock by two^k
// - Mode locked while enabled, except irq bit
// - Mode reset: high 00H, low 20H
// - Bit 15 picks shared clock A or B
// - Bit 14 picks divided clock or pin
// - Edge detector on op clock, rest transfer
// - Channel 1 start trigger: software or edge
// - Channel 1 receive inversion flips edge, data
// - Mode field: CSI, UART, I2C, 11 prohibited
// - Irq source: transfer end or buffer empty
// - Divider setting max gives divide by 256
module scm_regs
    import scm_pkg::*;
#(
    parameter int DIV_W = 7
) (
    input wire logic CORE_CLK,                  // Peripheral clock, 200 MHz
    input wire logic RST_N,                     // Async system reset, active low
    input wire logic CE,                        // Clock enable, freezes state when low
    input wire scm_pkg::scm_bus_t BUS,          // CPU SFR write strobe, address, data
    input wire logic [19:0] RD_ADDR,            // CPU read address
    output logic [7:0] RD_DATA,                 // Read data for RD_ADDR
    input wire logic [1:0] CHAN_ENABLED,        // Channel enabled status from channel logic
    input wire logic [1:0][DIV_W-1:0] DIVIDER,  // Divider setting per channel, from data high byte
    input wire logic SERIAL_CLOCK_PIN,          // External transfer clock pin (shared)
    output logic UNIT_CLK_EN,                   // Unit input clock gate
    output logic UNIT_RESET,                    // Unit held in reset
    output logic SHARED_OP_CLOCK_A,             // Shared operation clock A enable pulse
    output logic SHARED_OP_CLOCK_B,             // Shared operation clock B enable pulse
    output logic [1:0] CHAN_OP_CLK,             // Channel operation clock enable (edge detector)
    output logic [1:0] CHAN_XFER_CLK,           // Channel transfer clock enable (shift, ctrl)
    output scm_pkg::scm_chan_cfg_t [1:0] CHAN_CFG // Decoded channel configuration
);
    import scm_pkg::*;

    // Divider compare is built for the 7-bit setting only
    if (DIV_W != 7) begin : g_bad_div_w
        $error("scm_regs: DIV_W must be 7");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] per;
        logic [7:0] pre;
        logic [1:0][7:0] mlo;
        logic [1:0][7:0] mhi;
        logic [PRESCALE_W-1:0] pcnt;
        logic [1:0][DIV_W:0] dcnt;
        logic [2:0] pin_sync;
        logic pin_level;
        logic ck_a;
        logic ck_b;
        logic [1:0] opclk;
        logic [1:0] xclk;
        logic [7:0] rdata;
    } scm_state_t;

    scm_state_t st;
    scm_state_t next_st;

    // Tick when the free counter's low k bits are all ones: one pulse per 2^k cycles
    function automatic logic div_tick(input logic [PRESCALE_W-1:0] cnt, input logic [3:0] k);
        logic [PRESCALE_W-1:0] m;
        m = PRESCALE_W'((16'h0001 << k) - 16'h0001);
        return (cnt & m) == m;
    endfunction : div_tick

    function automatic logic [7:0] masked(input logic [7:0] old, input logic [7:0] wd,
                                          input logic [7:0] wmask, input logic [7:0] fixed);
        return (((old & ~wmask) | (wd & wmask)) & wmask) | (fixed & ~wmask);
    endfunction : masked

    logic unit_on;
    assign unit_on = st.per[UNIT_EN_BIT];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic sel;
        logic [7:0] wm_hi;
        logic [7:0] wm_lo;
        sel = 1'b0;
        wm_hi = 8'h00;
        wm_lo = 8'h00;
        next_st = st;
        // Software enable register; stays writable always
        if (BUS.wr && BUS.addr == ADDR_PERIPHERAL_CLOCK_ENABLE) begin
            next_st.per = BUS.wdata;
        end
        if (!unit_on) begin
            // Disabled unit: controls at defaults, writes dropped
            next_st.pre = RST_PRESCALER;
            next_st.mlo = {RST_MODE_LOW, RST_MODE_LOW};
            next_st.mhi = {RST_MODE_HIGH, RST_MODE_HIGH};
            next_st.pcnt = '0;
            next_st.dcnt = '0;
        end else begin
            if (BUS.wr && BUS.addr == ADDR_SERIAL_PRESCALER_SELECT) begin
                next_st.pre = BUS.wdata; // relies on software honouring the lock
            end
            for (int n = 0; n < 2; n++) begin
                wm_hi = (n == 0) ? MASK_C0_HIGH : MASK_C1_HIGH;
                wm_lo = (n == 0) ? MASK_C0_LOW : MASK_C1_LOW;
                // Only the irq source bit is writable while the channel runs
                if (CHAN_ENABLED[n]) begin
                    wm_hi = 8'h00;
                    wm_lo = MASK_IRQ_ONLY;
                end
                sel = BUS.wr && BUS.addr == ((n == 0) ? ADDR_CHAN0_MODE_HIGH : ADDR_CHAN1_MODE_HIGH);
                if (sel) begin
                    next_st.mhi[n] = (st.mhi[n] & ~wm_hi) | (BUS.wdata & wm_hi);
                end
                sel = BUS.wr && BUS.addr == ((n == 0) ? ADDR_CHAN0_MODE_LOW : ADDR_CHAN1_MODE_LOW);
                if (sel) begin
                    next_st.mlo[n] = (st.mlo[n] & ~wm_lo) | (BUS.wdata & wm_lo);
                end
            end
            next_st.pcnt = st.pcnt + 1'b1;
        end
        // Two shared clocks from the two nibbles
        next_st.ck_a = unit_on && div_tick(st.pcnt, st.pre[3:0]);
        next_st.ck_b = unit_on && div_tick(st.pcnt, st.pre[7:4]);
        // Pin sampled through three flops; change accepted when last two agree
        next_st.pin_sync = {st.pin_sync[1:0], SERIAL_CLOCK_PIN};
        if (st.pin_sync[2] == st.pin_sync[1]) begin
            next_st.pin_level = st.pin_sync[2];
        end
        for (int n = 0; n < 2; n++) begin
            // Channel op clock chosen by bit 15
            next_st.opclk[n] = st.mhi[n][H_OP_CLK_SEL] ? next_st.ck_b : next_st.ck_a;
            if (st.mhi[n][H_XFER_SRC]) begin
                // Slave transfer clock: rising edge of the filtered pin
                next_st.xclk[n] = unit_on && !st.pin_level && st.pin_sync[2] && st.pin_sync[1];
                next_st.dcnt[n] = '0;
            end else if (unit_on && st.opclk[n]) begin
                // Divide op clock by 2*(setting+1): max setting gives /256
                if (st.dcnt[n] == {DIVIDER[n], 1'b1}) begin
                    next_st.dcnt[n] = '0;
                    next_st.xclk[n] = 1'b1;
                end else begin
                    next_st.dcnt[n] = st.dcnt[n] + 1'b1;
                    next_st.xclk[n] = 1'b0;
                end
            end else begin
                next_st.xclk[n] = 1'b0;
            end
        end
        // Registered read mux; fixed bits forced to their reset values by the masks
        case (RD_ADDR)
            ADDR_PERIPHERAL_CLOCK_ENABLE: next_st.rdata = st.per;
            ADDR_SERIAL_PRESCALER_SELECT: next_st.rdata = st.pre;
            ADDR_CHAN0_MODE_LOW: next_st.rdata = masked(st.mlo[0], st.mlo[0], MASK_C0_LOW, RST_MODE_LOW);
            ADDR_CHAN0_MODE_HIGH: next_st.rdata = masked(st.mhi[0], st.mhi[0], MASK_C0_HIGH, RST_MODE_HIGH);
            ADDR_CHAN1_MODE_LOW: next_st.rdata = masked(st.mlo[1], st.mlo[1], MASK_C1_LOW, RST_MODE_LOW);
            ADDR_CHAN1_MODE_HIGH: next_st.rdata = masked(st.mhi[1], st.mhi[1], MASK_C1_HIGH, RST_MODE_HIGH);
            default: next_st.rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= '0;
            st.per <= RST_PER;
            st.pre <= RST_PRESCALER;
            st.mlo <= {RST_MODE_LOW, RST_MODE_LOW};
            st.mhi <= {RST_MODE_HIGH, RST_MODE_HIGH};
        end else if (CE) begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign UNIT_CLK_EN = unit_on;
    assign UNIT_RESET = !unit_on;
    assign RD_DATA = st.rdata;
    assign SHARED_OP_CLOCK_A = st.ck_a;
    assign SHARED_OP_CLOCK_B = st.ck_b;
    // Edge detector runs on op clock, engine on transfer clock
    assign CHAN_OP_CLK = st.opclk;
    assign CHAN_XFER_CLK = st.xclk;

    // Decoded per-channel configuration; channel-1-only bits read zero on channel 0
    always_comb begin
        for (int n = 0; n < 2; n++) begin
            CHAN_CFG[n].op_clk_b = st.mhi[n][H_OP_CLK_SEL];
            CHAN_CFG[n].xfer_ext = st.mhi[n][H_XFER_SRC];
            CHAN_CFG[n].start_on_rx_edge = st.mhi[n][H_START_TRIG];
            CHAN_CFG[n].rx_invert = st.mlo[n][L_RX_INVERT];
            CHAN_CFG[n].mode = scm_mode_t'({st.mlo[n][L_MODE_HI], st.mlo[n][L_MODE_LO]});
            CHAN_CFG[n].irq_buffer_empty = st.mlo[n][L_IRQ_SRC];
        end
    end

endmodule : scm_regs

// ==== verilog/scm_pkg.sv ====
// Constants, register map and carrier types for the serial unit clock/mode register slice.
// Assumes a single peripheral clock domain and an 8-bit SFR write/read port from the CPU.
package scm_pkg;

    // ------------------------------------------------------------
    // Register addresses (20-bit SFR space)
    // ------------------------------------------------------------
    localparam logic [19:0] ADDR_PERIPHERAL_CLOCK_ENABLE = 20'hf00f0;
    localparam logic [19:0] ADDR_CHAN0_MODE_LOW = 20'hf0110;
    localparam logic [19:0] ADDR_CHAN0_MODE_HIGH = 20'hf0111;
    localparam logic [19:0] ADDR_CHAN1_MODE_LOW = 20'hf0112;
    localparam logic [19:0] ADDR_CHAN1_MODE_HIGH = 20'hf0113;
    localparam logic [19:0] ADDR_SERIAL_PRESCALER_SELECT = 20'hf0126;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PER = 8'h00;
    localparam logic [7:0] RST_MODE_LOW = 8'h20;
    localparam logic [7:0] RST_MODE_HIGH = 8'h00;
    localparam logic [7:0] RST_PRESCALER = 8'h00;
    localparam int UNIT_EN_BIT = 2;
    localparam int H_OP_CLK_SEL = 7;   // bit 15 of full register
    localparam int H_XFER_SRC = 6;     // bit 14
    localparam int H_START_TRIG = 0;   // bit 8
    localparam int L_RX_INVERT = 6;
    localparam int L_MODE_HI = 2;
    localparam int L_MODE_LO = 1;
    localparam int L_IRQ_SRC = 0;
    // Writable-bit masks; everything else reads back at the reset value
    localparam logic [7:0] MASK_C0_HIGH = 8'hc0;
    localparam logic [7:0] MASK_C1_HIGH = 8'hc1;
    localparam logic [7:0] MASK_C0_LOW = 8'h07;
    localparam logic [7:0] MASK_C1_LOW = 8'h47;
    localparam logic [7:0] MASK_IRQ_ONLY = 8'h01;
    localparam int PRESCALE_W = 15;

    // Protocol modes of the two-bit mode field
    typedef enum logic [1:0] {
        SCM_MODE_CSI = 2'b00,
        SCM_MODE_UART = 2'b01,
        SCM_MODE_IIC = 2'b10,
        SCM_MODE_BAD = 2'b11
    } scm_mode_t;

    // CPU SFR access carrier
    typedef struct packed {
        logic wr;
        logic [19:0] addr;
        logic [7:0] wdata;
    } scm_bus_t;

    // Per-channel decoded configuration
    typedef struct packed {
        logic op_clk_b;
        logic xfer_ext;
        logic start_on_rx_edge;
        logic rx_invert;
        scm_mode_t mode;
        logic irq_buffer_empty;
    } scm_chan_cfg_t;

endpackage : scm_pkg

// ==== tb/scm_regs_asserts.sv ====
// Checker for the serial unit clock and mode register slice.
// Assumes it is bound onto scm_regs and sees its ports only.
module scm_regs_asserts
    import scm_pkg::*;
(
    input wire logic CORE_CLK, // Peripheral clock
    input wire logic RST_N, // Async reset, active low
    input wire logic CE, // Clock enable
    input wire scm_pkg::scm_bus_t BUS, // CPU write port
    input wire logic [19:0] RD_ADDR, // Read address
    input wire logic [7:0] RD_DATA, // Read data
    input wire logic [1:0] CHAN_ENABLED, // Channel enabled status
    input wire logic UNIT_CLK_EN, // Unit clock gate
    input wire logic UNIT_RESET, // Unit reset
    input wire logic SHARED_OP_CLOCK_A, // Shared clock A
    input wire logic SHARED_OP_CLOCK_B, // Shared clock B
    input wire scm_pkg::scm_chan_cfg_t [1:0] CHAN_CFG // Channel config
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    logic [3:0] psc_lo;
    logic wr_ok;
    // Shadow of the prescaler low nibble, cleared with the unit gate
    assign wr_ok = CE && BUS.wr && UNIT_CLK_EN;
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) psc_lo <= 4'h0;
        else if (!UNIT_CLK_EN) psc_lo <= 4'h0;
        else if (wr_ok && BUS.addr == ADDR_SERIAL_PRESCALER_SELECT) psc_lo <= BUS.wdata[3:0];
    end
    chk_reset_tracks: assert property (UNIT_RESET == !UNIT_CLK_EN) else $error("reset not inverse of gate");
    chk_off_clocks: assert property (!UNIT_CLK_EN && $past(!UNIT_CLK_EN) |-> !SHARED_OP_CLOCK_A && !SHARED_OP_CLOCK_B)
        else $error("clock pulse while unit off");
    chk_off_defaults: assert property (!UNIT_CLK_EN && $past(!UNIT_CLK_EN) |-> CHAN_CFG == '0)
        else $error("config not default while unit off");
    chk_per_read: assert property ($past(RST_N) && $past(CE) && $past(RD_ADDR) == ADDR_PERIPHERAL_CLOCK_ENABLE
        |-> RD_DATA[2] == $past(UNIT_CLK_EN)) else $error("enable bit read wrong");
    chk_psc_a_rate: assert property (psc_lo == 4'h0 && $past(psc_lo == 4'h0, 3) && UNIT_CLK_EN && $past(UNIT_CLK_EN, 3)
        && $past(UNIT_CLK_EN) && CE && $past(CE) |-> SHARED_OP_CLOCK_A) else $error("clock A missing at divide by one");
    chk_mode_write: assert property (wr_ok && BUS.addr == ADDR_CHAN1_MODE_LOW && !CHAN_ENABLED[1]
        |=> CHAN_CFG[1].mode == $past(BUS.wdata[2:1])) else $error("mode field not taken");
    chk_irq_unlocked: assert property (wr_ok && BUS.addr == ADDR_CHAN0_MODE_LOW && CHAN_ENABLED[0]
        |=> $stable(CHAN_CFG[0].mode) && CHAN_CFG[0].irq_buffer_empty == $past(BUS.wdata[0])) else $error("lock wrong");
    chk_high_write: assert property (wr_ok && BUS.addr == ADDR_CHAN1_MODE_HIGH && !CHAN_ENABLED[1]
        |=> {CHAN_CFG[1].op_clk_b, CHAN_CFG[1].xfer_ext, CHAN_CFG[1].start_on_rx_edge} == $past({BUS.wdata[7:6], BUS.wdata[0]}))
        else $error("high byte fields not taken");
    chk_low_fixed: assert property ($past(RST_N) && $past(CE) && $past(RD_ADDR) == ADDR_CHAN1_MODE_LOW
        |-> !RD_DATA[7] && RD_DATA[5:3] == 3'b100) else $error("fixed bits read wrong");
endmodule : scm_regs_asserts
bind scm_regs scm_regs_asserts u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE), .BUS(BUS), .RD_ADDR(RD_ADDR),
    .RD_DATA(RD_DATA), .CHAN_ENABLED(CHAN_ENABLED), .UNIT_CLK_EN(UNIT_CLK_EN), .UNIT_RESET(UNIT_RESET),
    .SHARED_OP_CLOCK_A(SHARED_OP_CLOCK_A), .SHARED_OP_CLOCK_B(SHARED_OP_CLOCK_B), .CHAN_CFG(CHAN_CFG));

// ==== tb/tb_scm_regs.sv ====
// Self-checking bench for the serial unit clock and mode registers.
// Assumes the bound checker; drives all inputs on the falling edge.
module tb_scm_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import scm_pkg::*;
    logic CORE_CLK = 0, RST_N = 0, CE = 1, SERIAL_CLOCK_PIN = 0, UNIT_CLK_EN, UNIT_RESET, SHARED_OP_CLOCK_A;
    logic SHARED_OP_CLOCK_B;
    scm_bus_t BUS = '0;
    logic [19:0] RD_ADDR = '0;
    logic [7:0] RD_DATA;
    logic [1:0] CHAN_ENABLED = '0, CHAN_OP_CLK, CHAN_XFER_CLK;
    logic [1:0][6:0] DIVIDER = '0;
    scm_chan_cfg_t [1:0] CHAN_CFG;
    int n_fail = 0, n_checks = 0, n[6];
    scm_regs #(.DIV_W(7)) dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE), .BUS(BUS), .RD_ADDR(RD_ADDR),
        .RD_DATA(RD_DATA), .CHAN_ENABLED(CHAN_ENABLED), .DIVIDER(DIVIDER), .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN),
        .UNIT_CLK_EN(UNIT_CLK_EN), .UNIT_RESET(UNIT_RESET), .SHARED_OP_CLOCK_A(SHARED_OP_CLOCK_A),
        .SHARED_OP_CLOCK_B(SHARED_OP_CLOCK_B), .CHAN_OP_CLK(CHAN_OP_CLK), .CHAN_XFER_CLK(CHAN_XFER_CLK),
        .CHAN_CFG(CHAN_CFG));
    // Compare, count, report at once
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Strobe held over one rising edge, a free cycle between writes
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(negedge CORE_CLK) BUS = '{1'b1, a, d};
        @(negedge CORE_CLK) BUS.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        @(negedge CORE_CLK) RD_ADDR = a;
        @(negedge CORE_CLK) chk(RD_DATA, e);
    endtask : rd
    // Pulse counts over a window that spans whole periods
    task automatic cnt(input int cyc);
        n = '{default: 0};
        repeat (cyc) begin
            @(negedge CORE_CLK);
            n[0] += SHARED_OP_CLOCK_A;
            n[1] += SHARED_OP_CLOCK_B;
            n[2] += CHAN_OP_CLK[0];
            n[3] += CHAN_OP_CLK[1];
            n[4] += CHAN_XFER_CLK[0];
            n[5] += CHAN_XFER_CLK[1];
        end
    endtask : cnt
    task automatic t_reset();
        chk(UNIT_RESET, 8'h01);
        rd(ADDR_PERIPHERAL_CLOCK_ENABLE, 8'h00);
        rd(ADDR_CHAN0_MODE_LOW, 8'h20);
        rd(ADDR_CHAN1_MODE_HIGH, 8'h00);
        rd(20'hf0114, 8'h00);
        wr(ADDR_CHAN0_MODE_LOW, 8'h07);
        rd(ADDR_CHAN0_MODE_LOW, 8'h20);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_fixed();
        wr(ADDR_PERIPHERAL_CLOCK_ENABLE, 8'h04);
        chk(UNIT_CLK_EN, 8'h01);
        wr(ADDR_CHAN0_MODE_HIGH, 8'hff);
        rd(ADDR_CHAN0_MODE_HIGH, 8'hc0);
        wr(ADDR_CHAN1_MODE_HIGH, 8'hff);
        rd(ADDR_CHAN1_MODE_HIGH, 8'hc1);
        wr(ADDR_CHAN0_MODE_LOW, 8'hff);
        rd(ADDR_CHAN0_MODE_LOW, 8'h27);
        wr(ADDR_CHAN1_MODE_LOW, 8'hff);
        rd(ADDR_CHAN1_MODE_LOW, 8'h67);
        chk(CHAN_CFG[0], 8'h67);
        chk(CHAN_CFG[1], 8'h7f);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CHAN1_MODE_LOW, 8'(m << 1));
            chk(CHAN_CFG[1].mode, 8'(m));
            chk(CHAN_CFG[1].rx_invert, 8'h00);
        end
        $display("t_fixed done");
    endtask : t_fixed
    task automatic t_lock();
        @(negedge CORE_CLK) CHAN_ENABLED = 2'b01;
        wr(ADDR_CHAN0_MODE_LOW, 8'h04);
        rd(ADDR_CHAN0_MODE_LOW, 8'h26);
        @(negedge CORE_CLK) CHAN_ENABLED = 2'b00;
        // Clock enable low: a write must not land
        CE = 1'b0;
        wr(ADDR_CHAN1_MODE_LOW, 8'h00);
        CE = 1'b1;
        rd(ADDR_CHAN1_MODE_LOW, 8'h26);
        $display("t_lock done");
    endtask : t_lock
    task automatic t_clocks();
        DIVIDER = {7'd0, 7'd1};
        wr(ADDR_CHAN0_MODE_HIGH, 8'h00);
        wr(ADDR_CHAN1_MODE_HIGH, 8'h80);
        wr(ADDR_SERIAL_PRESCALER_SELECT, 8'h32); // channels stopped
        repeat (40) @(negedge CORE_CLK);
        cnt(128);
        foreach (n[i]) chk(8'(n[i]), i < 3 ? (i == 1 ? 8'd16 : 8'd32) : (i == 3 ? 8'd16 : 8'd8));
        wr(ADDR_CHAN1_MODE_HIGH, 8'h40);
        fork
            cnt(200);
            repeat (6) begin
                repeat (16) @(negedge CORE_CLK);
                SERIAL_CLOCK_PIN = ~SERIAL_CLOCK_PIN;
            end
        join
        chk(8'(n[5]), 8'd3);
        $display("t_clocks done");
    endtask : t_clocks
    task automatic t_off();
        wr(ADDR_PERIPHERAL_CLOCK_ENABLE, 8'h00);
        chk(UNIT_RESET, 8'h01);
        rd(ADDR_CHAN1_MODE_HIGH, 8'h00);
        rd(ADDR_SERIAL_PRESCALER_SELECT, 8'h00);
        cnt(16);
        chk(8'(n[0] + n[1]), 8'd0);
        $display("t_off done");
    endtask : t_off
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    // Clock, reset, sequence and hang guard
    initial forever #2.5 CORE_CLK = ~CORE_CLK;
    initial begin
        repeat (10) @(negedge CORE_CLK);
        RST_N = 1;
        t_reset();
        t_fixed();
        t_lock();
        t_clocks();
        t_off();
        close_out();
    end
    initial begin
        #50000;
        n_fail++;
        close_out();
    end
endmodule : tb_scm_regs
